// file: verilog/rlpc_pkg.sv
// Constants for the reset and low-power control block.
// Assumes one 250 MHz system clock that also serves as the bus clock.
package rlpc_pkg;

    // ------------------------------------------------------------
    // Stabilisation delays, in bus clock cycles
    // ------------------------------------------------------------
    localparam int unsigned STAB_W = 12;
    localparam logic [STAB_W-1:0] STAB_SHORT = 12'h010;
    localparam logic [STAB_W-1:0] STAB_LONG = 12'hfe0;
    localparam logic [STAB_W-1:0] STAB_ONE = 12'h001;
    localparam logic [STAB_W-1:0] STAB_ZERO = 12'h000;

    // ------------------------------------------------------------
    // Fetch address space
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 16;
    localparam logic [ADDR_W-1:0] IO_AREA_LAST = 16'h001f;

    // ------------------------------------------------------------
    // Low-power states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LP_RUN,
        LP_STOP,
        LP_HALT,
        LP_WAIT,
        LP_RESTART
    } rlpc_lp_t;

endpackage : rlpc_pkg

// file: verilog/rlpc_src_if.sv
// Reset sources and the combined reset between top and latch.
// Assumes both ends share clk_sys.
interface rlpc_src_if;
    logic por_active;
    logic ext_low;
    logic wdog_hit;
    logic bad_fetch;
    logic rst;
    logic pin_pulldown;

    modport src (
        output por_active,
        output ext_low,
        output wdog_hit,
        output bad_fetch,
        input rst,
        input pin_pulldown
    );

    modport latch (
        input por_active,
        input ext_low,
        input wdog_hit,
        input bad_fetch,
        output rst,
        output pin_pulldown
    );
endinterface : rlpc_src_if

// file: verilog/rlpc_stab_timer.sv
// Oscillator stabilisation timer, 16 or 4064 bus cycles.
// Assumes start is a one-cycle pulse; a new start reloads.
module rlpc_stab_timer (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start,
    input wire logic long_sel,
    output logic busy,
    output logic done
);

    logic [rlpc_pkg::STAB_W-1:0] count_reg;
    logic busy_reg;
    logic done_reg;

    // ------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_reg <= rlpc_pkg::STAB_ZERO;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (start) begin
            count_reg <= long_sel ? rlpc_pkg::STAB_LONG : rlpc_pkg::STAB_SHORT;
            busy_reg <= 1'b1;
            done_reg <= 1'b0;
        end else if (busy_reg) begin
            count_reg <= count_reg - rlpc_pkg::STAB_ONE;
            busy_reg <= (count_reg != rlpc_pkg::STAB_ONE);
            done_reg <= (count_reg == rlpc_pkg::STAB_ONE);
        end else begin
            done_reg <= 1'b0;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;

endmodule : rlpc_stab_timer

// file: verilog/rlpc_reset_latch.sv
// Reset latch: any source sets it, it clears once all have ended.
// Assumes sources are synchronous to clk_sys.
module rlpc_reset_latch (
    input wire logic clk_sys,
    input wire logic reset,
    rlpc_src_if.latch src
);

    logic rst_reg;
    logic pulldown_reg;
    logic any_src;

    assign any_src = src.por_active | src.ext_low | src.wdog_hit | src.bad_fetch;

    // ------------------------------------------------------------
    // Combined reset
    // ------------------------------------------------------------
    // Cleared only when no source is left, so ends never overlap badly
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rst_reg <= 1'b1;
        end else begin
            rst_reg <= any_src;
        end
    end

    // ------------------------------------------------------------
    // Reset pin pulldown, one bus cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pulldown_reg <= 1'b0;
        end else begin
            pulldown_reg <= src.wdog_hit | src.bad_fetch;
        end
    end

    assign src.rst = rst_reg;
    assign src.pin_pulldown = pulldown_reg;

endmodule : rlpc_reset_latch

// file: verilog/rlpc_top.sv
// Reset combiner and low-power sequencer of a small controller.
// Assumes all inputs are synchronous to clk_sys; reset is power-on.
module rlpc_top (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic opt_long_delay,
    input wire logic opt_wdog_fitted,
    input wire logic opt_stop_is_halt,
    input wire logic opt_porta_irq,
    input wire logic osc_ready,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic wdog_timeout,
    input wire logic fetch_valid,
    input wire logic [rlpc_pkg::ADDR_W-1:0] fetch_addr,
    input wire logic stop_exec,
    input wire logic wait_exec,
    input wire logic ext_irq_event,
    input wire logic porta_irq_event,
    input wire logic timer_irq_pending,
    input wire logic serial_prog_select,
    input wire logic irq_pin_in,
    input wire logic port_b_bit0_in,
    output logic internal_reset,
    output logic osc_enable,
    output logic cpu_clock_enable,
    output logic timer_clock_enable,
    output logic wdog_clock_enable,
    output logic clear_timer_bits,
    output logic clear_irq_mask,
    output logic set_ext_irq_enable,
    output logic [2:0] lp_state,
    output logic serial_prog_mode,
    output logic nvm_serial_clk,
    output logic nvm_serial_data
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    rlpc_src_if srcs ();

    rlpc_pkg::rlpc_lp_t lp_reg;
    rlpc_pkg::rlpc_lp_t lp_next;
    logic por_wait_osc_reg;
    logic por_active_reg;
    logic rst_prev_reg;
    logic serial_mode_reg;
    logic nvm_clk_reg;
    logic nvm_data_reg;
    logic clear_timer_reg;
    logic clear_mask_reg;
    logic set_ext_irq_enable_reg;
    logic stab_start;
    logic from_stop_reg;
    logic stab_done;
    logic rst;
    logic cpu_running;
    logic stop_wake;
    logic halt_wake;
    logic enter_stop;
    logic enter_halt;
    logic enter_wait;
    logic wdog_running;

    // ------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------
    assign rst = srcs.rst;
    // Requests count only in run with reset released
    assign cpu_running = (lp_reg == rlpc_pkg::LP_RUN) && !rst;
    // A stop restart keeps the counter frozen; a halt restart does not
    assign wdog_running = (lp_reg != rlpc_pkg::LP_STOP)
        && !(lp_reg == rlpc_pkg::LP_RESTART && from_stop_reg);

    assign srcs.ext_low = !reset_pin_in;
    // Stalled watchdog clock in stop cannot time out
    assign srcs.wdog_hit = opt_wdog_fitted && wdog_timeout && wdog_running;
    // Only fetches issued while the CPU runs count
    assign srcs.bad_fetch = cpu_running && fetch_valid && (fetch_addr <= rlpc_pkg::IO_AREA_LAST);
    assign srcs.por_active = por_active_reg;

    rlpc_reset_latch u_latch (
        .clk_sys(clk_sys),
        .reset(reset),
        .src(srcs)
    );

    // ------------------------------------------------------------
    // Power-on delay
    // ------------------------------------------------------------
    // Delay starts only once the oscillator reports running
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            por_wait_osc_reg <= 1'b1;
        end else if (osc_ready) begin
            por_wait_osc_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            por_active_reg <= 1'b1;
        end else if (!por_wait_osc_reg && stab_done) begin
            por_active_reg <= 1'b0;
        end
    end

    // One timer serves both power-up and stop/halt restart
    assign stab_start = (por_wait_osc_reg && osc_ready)
        || (!rst && lp_reg != rlpc_pkg::LP_RESTART && lp_next == rlpc_pkg::LP_RESTART);

    rlpc_stab_timer u_stab (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(stab_start),
        .long_sel(opt_long_delay),
        .busy(),
        .done(stab_done)
    );

    // ------------------------------------------------------------
    // Low-power sequencer
    // ------------------------------------------------------------
    // Stop wins when both instructions arrive together
    assign enter_stop = cpu_running && stop_exec && !opt_stop_is_halt;
    assign enter_halt = cpu_running && stop_exec && opt_stop_is_halt;
    assign enter_wait = cpu_running && wait_exec && !stop_exec;
    assign stop_wake = ext_irq_event || (opt_porta_irq && porta_irq_event);
    assign halt_wake = ext_irq_event || timer_irq_pending;

    always_comb begin
        lp_next = lp_reg;
        case (lp_reg)
            rlpc_pkg::LP_RUN: begin
                if (enter_stop) begin
                    lp_next = rlpc_pkg::LP_STOP;
                end else if (enter_halt) begin
                    lp_next = rlpc_pkg::LP_HALT;
                end else if (enter_wait) begin
                    lp_next = rlpc_pkg::LP_WAIT;
                end
            end
            rlpc_pkg::LP_STOP: begin
                if (stop_wake) begin
                    lp_next = rlpc_pkg::LP_RESTART;
                end
            end
            rlpc_pkg::LP_HALT: begin
                if (halt_wake) begin
                    lp_next = rlpc_pkg::LP_RESTART;
                end
            end
            rlpc_pkg::LP_WAIT: begin
                if (halt_wake) begin
                    lp_next = rlpc_pkg::LP_RUN;
                end
            end
            rlpc_pkg::LP_RESTART: begin
                if (stab_done) begin
                    lp_next = rlpc_pkg::LP_RUN;
                end
            end
            default: begin
                lp_next = rlpc_pkg::LP_RUN;
            end
        endcase
    end

    // External reset exits every mode through the latch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lp_reg <= rlpc_pkg::LP_RUN;
        end else if (rst) begin
            lp_reg <= rlpc_pkg::LP_RUN;
        end else begin
            lp_reg <= lp_next;
        end
    end

    // ------------------------------------------------------------
    // Restart origin
    // ------------------------------------------------------------
    // Halt restart keeps watchdog and timers alive, stop restart does not
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            from_stop_reg <= 1'b0;
        end else if (enter_stop) begin
            from_stop_reg <= 1'b1;
        end else if (enter_halt || rst) begin
            from_stop_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Entry side effects, one-cycle pulses
    // ------------------------------------------------------------
    // Only true stop touches timer state; halt keeps it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clear_timer_reg <= 1'b0;
        end else begin
            clear_timer_reg <= enter_stop;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clear_mask_reg <= 1'b0;
            set_ext_irq_enable_reg <= 1'b0;
        end else begin
            clear_mask_reg <= enter_stop || enter_halt || enter_wait;
            set_ext_irq_enable_reg <= enter_stop || enter_halt || enter_wait;
        end
    end

    // ------------------------------------------------------------
    // Clock gating
    // ------------------------------------------------------------
    // Oscillator off only in true stop; halt leaves it running
    assign osc_enable = (lp_reg != rlpc_pkg::LP_STOP);
    assign wdog_clock_enable = wdog_running;
    assign timer_clock_enable = (lp_reg == rlpc_pkg::LP_RUN)
        || (lp_reg == rlpc_pkg::LP_HALT) || (lp_reg == rlpc_pkg::LP_WAIT)
        || (lp_reg == rlpc_pkg::LP_RESTART && !from_stop_reg);
    // CPU clock held in every low-power state and in serial mode
    assign cpu_clock_enable = (lp_reg == rlpc_pkg::LP_RUN) && !serial_mode_reg;

    // ------------------------------------------------------------
    // Serial programming mode
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        rst_prev_reg <= reset ? 1'b1 : rst;
    end

    // Mode is sampled on the reset release edge only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            serial_mode_reg <= 1'b0;
        end else if (rst) begin
            serial_mode_reg <= 1'b0;
        end else if (rst_prev_reg) begin
            serial_mode_reg <= serial_prog_select;
        end
    end

    // Pins copied only in serial mode, else held low
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            nvm_clk_reg <= 1'b0;
            nvm_data_reg <= 1'b0;
        end else if (serial_mode_reg) begin
            nvm_clk_reg <= irq_pin_in;
            nvm_data_reg <= port_b_bit0_in;
        end else begin
            nvm_clk_reg <= 1'b0;
            nvm_data_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign internal_reset = rst;
    // Open drain: the pin is only ever pulled low
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = srcs.pin_pulldown;
    assign clear_timer_bits = clear_timer_reg;
    assign clear_irq_mask = clear_mask_reg;
    assign set_ext_irq_enable = set_ext_irq_enable_reg;
    assign lp_state = lp_reg;
    assign serial_prog_mode = serial_mode_reg;
    assign nvm_serial_clk = nvm_clk_reg;
    assign nvm_serial_data = nvm_data_reg;

endmodule : rlpc_top

// file: verif/rlpc_pin_model.sv
// External reset pin with its pull-up and the party that holds it.
// Assumes an open-drain pin: any pull low wins over the pull-up.
module rlpc_pin_model (
    input wire logic ext_hold_low,
    input wire logic reset_pin_oe,
    input wire logic reset_pin_out,
    output logic reset_pin_in
);
    // Released pin floats to the pull-up, never to the last level
    assign reset_pin_in = !(ext_hold_low || (reset_pin_oe && !reset_pin_out));
endmodule : rlpc_pin_model

// file: verif/rlpc_props.sv
// Checker of the reset combiner and low-power sequencer ports.
// Assumes it is bound to rlpc_top; one clock domain.
module rlpc_props (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic opt_long_delay,
    input wire logic opt_wdog_fitted,
    input wire logic opt_stop_is_halt,
    input wire logic opt_porta_irq,
    input wire logic reset_pin_in,
    input wire logic reset_pin_oe,
    input wire logic wdog_timeout,
    input wire logic fetch_valid,
    input wire logic [rlpc_pkg::ADDR_W-1:0] fetch_addr,
    input wire logic stop_exec,
    input wire logic ext_irq_event,
    input wire logic porta_irq_event,
    input wire logic internal_reset,
    input wire logic osc_enable,
    input wire logic cpu_clock_enable,
    input wire logic timer_clock_enable,
    input wire logic wdog_clock_enable,
    input wire logic clear_timer_bits,
    input wire logic clear_irq_mask,
    input wire logic set_ext_irq_enable,
    input wire logic [2:0] lp_state
);
    // ------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------
    logic wd_c;
    logic bf_c;
    logic calm;
    assign wd_c = opt_wdog_fitted && wdog_timeout && lp_state != 3'h1 && !(lp_state == 3'h4 && !opt_stop_is_halt);
    assign bf_c = fetch_valid && fetch_addr <= 16'h001f && lp_state == 3'h0 && !internal_reset;
    // Excludes edges where a new reset would preempt the instruction
    assign calm = reset_pin_in && !wd_c && !bf_c && !internal_reset && lp_state == 3'h0;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_WDOG_PULL: assert property (wd_c |=> reset_pin_oe && internal_reset)
        else $error("watchdog timeout without reset and pulldown");
    AST_FETCH_RST: assert property (bf_c |=> reset_pin_oe && internal_reset)
        else $error("bad fetch without reset and pulldown");
    AST_PULL_CAUSE: assert property (reset_pin_oe |-> $past(wd_c || bf_c))
        else $error("pulldown without a cause");
    AST_EXT_HOLD: assert property (!reset_pin_in |=> internal_reset)
        else $error("low reset pin did not hold reset");
    AST_STOP_IN: assert property (calm && stop_exec && !opt_stop_is_halt |=> lp_state == 3'h1 && !osc_enable
        && !wdog_clock_enable && !cpu_clock_enable && clear_timer_bits && clear_irq_mask && set_ext_irq_enable)
        else $error("stop entry wrong");
    AST_HALT_IN: assert property (calm && stop_exec && opt_stop_is_halt |=> lp_state == 3'h2 && osc_enable
        && wdog_clock_enable && timer_clock_enable && !cpu_clock_enable && !clear_timer_bits && set_ext_irq_enable)
        else $error("halt entry wrong");
    AST_STOP_HOLD: assert property (lp_state == 3'h1 && !ext_irq_event && !(opt_porta_irq && porta_irq_event)
        && reset_pin_in && !internal_reset |=> lp_state == 3'h1)
        else $error("stop left without a wake source");
    AST_RESTART_LEN: assert property (disable iff (reset || internal_reset)
        $rose(lp_state == 3'h4) && !opt_long_delay |-> (lp_state == 3'h4) [*8] ##[9:12] lp_state == 3'h0)
        else $error("restart delay out of range");
    AST_RST_RUN: assert property (internal_reset |=> lp_state == 3'h0)
        else $error("reset did not cancel low power");
    AST_POR_HOLD: assert property ($fell(reset) |-> internal_reset [*8])
        else $error("power-on delay too short");
    cover property (lp_state == 3'h1 ##1 lp_state == 3'h4);
    cover property (lp_state == 3'h2 ##1 internal_reset);
    cover property ($fell(internal_reset));
endmodule : rlpc_props
bind rlpc_top rlpc_props props_u (.clk_sys, .reset, .opt_long_delay, .opt_wdog_fitted, .opt_stop_is_halt,
    .opt_porta_irq, .reset_pin_in, .reset_pin_oe, .wdog_timeout, .fetch_valid, .fetch_addr, .stop_exec,
    .ext_irq_event, .porta_irq_event, .internal_reset, .osc_enable, .cpu_clock_enable, .timer_clock_enable,
    .wdog_clock_enable, .clear_timer_bits, .clear_irq_mask, .set_ext_irq_enable, .lp_state);

// file: verif/testbench.sv
// Self-checking bench of the reset combiner and low-power sequencer.
// Assumes the package, design, pin model and checker compile first.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset, opt_long_delay, opt_wdog_fitted, opt_stop_is_halt, opt_porta_irq, osc_ready;
    logic ext_hold_low, wdog_timeout, fetch_valid, stop_exec, wait_exec, ext_irq_event, porta_irq_event;
    logic timer_irq_pending, serial_prog_select, irq_pin_in, port_b_bit0_in, reset_pin_in, reset_pin_out;
    logic reset_pin_oe, internal_reset, osc_enable, cpu_clock_enable, timer_clock_enable, wdog_clock_enable;
    logic clear_timer_bits, clear_irq_mask, set_ext_irq_enable, serial_prog_mode, nvm_serial_clk, nvm_serial_data;
    logic [15:0] fetch_addr;
    logic [2:0] lp_state;
    logic [15:0] tbl [4] = '{16'h0000, 16'h001f, 16'h0020, 16'hffff};
    int n_mismatch = 0;
    int num_checks = 0;
    rlpc_top dut_u (.clk_sys, .reset, .opt_long_delay, .opt_wdog_fitted, .opt_stop_is_halt, .opt_porta_irq,
        .osc_ready, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .wdog_timeout, .fetch_valid, .fetch_addr,
        .stop_exec, .wait_exec, .ext_irq_event, .porta_irq_event, .timer_irq_pending, .serial_prog_select,
        .irq_pin_in, .port_b_bit0_in, .internal_reset, .osc_enable, .cpu_clock_enable, .timer_clock_enable,
        .wdog_clock_enable, .clear_timer_bits, .clear_irq_mask, .set_ext_irq_enable, .lp_state,
        .serial_prog_mode, .nvm_serial_clk, .nvm_serial_data);
    rlpc_pin_model pin_u (.ext_hold_low, .reset_pin_oe, .reset_pin_out, .reset_pin_in);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    task automatic cyc();
        @(posedge clk_sys);
        #1;
    endtask : cyc
    // Bounded wait for reset release or for run state
    task automatic wait_until(input logic on_lp, output int n);
        n = 0;
        while ((on_lp ? lp_state !== 3'h0 : internal_reset !== 1'b0) && n < 5000) begin
            cyc();
            n++;
        end
        if (n >= 5000) begin
            check("timeout", 1, 0);
            results();
        end
    endtask : wait_until
    task automatic por(input logic long_sel, input logic hold, input int dly);
        int n;
        @(posedge clk_sys);
        reset <= 1'b1;
        osc_ready <= 1'b0;
        opt_long_delay <= long_sel;
        ext_hold_low <= hold;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        // Delay must count from the oscillator, not from release
        repeat (dly) @(posedge clk_sys);
        osc_ready <= 1'b1;
        #1;
        if (hold) begin
            repeat (30) cyc();
            check("rst_held", internal_reset, 1);
            @(posedge clk_sys);
            ext_hold_low <= 1'b0;
            #1;
        end
        wait_until(1'b0, n);
        check("por_len", n, hold ? 1 : int'(long_sel ? rlpc_pkg::STAB_LONG : rlpc_pkg::STAB_SHORT) + 3);
    endtask : por
    // Pin echo of the pulldown extends reset by one cycle
    task automatic hit(input logic wd, input logic [15:0] a);
        int n;
        logic bad;
        @(posedge clk_sys);
        bad = wd ? opt_wdog_fitted : (a <= 16'h001f);
        wdog_timeout <= wd;
        fetch_valid <= !wd;
        fetch_addr <= a;
        @(posedge clk_sys);
        wdog_timeout <= 1'b0;
        fetch_valid <= 1'b0;
        #1;
        check("pull", {reset_pin_oe, reset_pin_out, internal_reset}, {bad, 1'b0, bad});
        cyc();
        check("pull_one", reset_pin_oe, 0);
        wait_until(1'b0, n);
        check("rst_end", n, bad);
    endtask : hit
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        int exp;
        logic [31:0] r;
        logic [1:0] q [$];
        {opt_long_delay, opt_wdog_fitted, opt_stop_is_halt, opt_porta_irq, ext_hold_low, wdog_timeout} = '0;
        {fetch_valid, stop_exec, wait_exec, ext_irq_event, porta_irq_event, timer_irq_pending} = '0;
        {serial_prog_select, irq_pin_in, port_b_bit0_in} = '0;
        reset = 1'b1;
        osc_ready = 1'b1;
        fetch_addr = 16'h0100;
        r = $urandom(32'h1132843b);
        por(1'b0, 1'b0, 0);
        por(1'b0, 1'b1, 3);
        por(1'b1, 1'b0, 0);
        por(1'b0, 1'b0, 6);
        $display("Test power-on done");
        for (int i = 0; i < 6; i++) begin
            hit(1'b0, (i < 4) ? tbl[i] : 16'($urandom));
        end
        for (int f = 0; f < 2; f++) begin
            @(posedge clk_sys);
            opt_wdog_fitted <= f[0];
            hit(1'b1, 16'h0100);
        end
        $display("Test reset sources done");
        for (int m = 0; m < 3; m++) begin
            exp = (m == 0) ? 3 : ((m == 1) ? 1 : 2);
            @(posedge clk_sys);
            opt_stop_is_halt <= (m == 2);
            opt_porta_irq <= 1'b0;
            stop_exec <= (m != 0);
            wait_exec <= (m == 0);
            @(posedge clk_sys);
            {stop_exec, wait_exec} <= 2'h0;
            timer_irq_pending <= (m == 1);
            porta_irq_event <= (m == 1);
            #1;
            check("lp_enter", lp_state, exp);
            check("clk_en", {osc_enable, cpu_clock_enable, timer_clock_enable, wdog_clock_enable},
                (m == 1) ? 4'h0 : 4'hb);
            check("side_fx", {clear_timer_bits, clear_irq_mask, set_ext_irq_enable}, {m == 1, 2'b11});
            repeat (3) cyc();
            check("lp_stay", lp_state, exp);
            @(posedge clk_sys);
            opt_porta_irq <= 1'b1;
            timer_irq_pending <= (m == 2);
            ext_irq_event <= (m == 0);
            @(posedge clk_sys);
            {timer_irq_pending, ext_irq_event, porta_irq_event} <= 3'h0;
            #1;
            check("restart_en", {osc_enable, wdog_clock_enable, timer_clock_enable}, {1'b1, m != 1, m != 1});
            wait_until(1'b1, n);
            check("wake_len", (m == 0) ? (n == 0) : (n >= 16 && n <= 19), 1);
            check("cpu_back", cpu_clock_enable, 1);
        end
        @(posedge clk_sys);
        opt_stop_is_halt <= 1'b1;
        opt_wdog_fitted <= 1'b1;
        stop_exec <= 1'b1;
        @(posedge clk_sys);
        stop_exec <= 1'b0;
        #1;
        check("halt", lp_state, 3'h2);
        hit(1'b1, 16'h0100);
        check("lp_reset", lp_state, 3'h0);
        $display("Test low power done");
        @(posedge clk_sys);
        serial_prog_select <= 1'b1;
        hit(1'b0, 16'h0005);
        repeat (2) cyc();
        check("smode", {serial_prog_mode, cpu_clock_enable}, 2'b10);
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_sys);
            r = $urandom;
            {irq_pin_in, port_b_bit0_in} <= r[1:0];
            #1;
            if (i > 0) check("nvm", {nvm_serial_clk, nvm_serial_data}, q.pop_front());
            q.push_back(r[1:0]);
        end
        @(posedge clk_sys);
        serial_prog_select <= 1'b0;
        ext_hold_low <= 1'b1;
        @(posedge clk_sys);
        ext_hold_low <= 1'b0;
        #1;
        wait_until(1'b0, n);
        repeat (2) cyc();
        check("smode_off", serial_prog_mode, 0);
        $display("Test serial done");
        results();
    end
endmodule : testbench
